// file: bbpw_pkg.sv
package bbpw_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_HZ        = 50_000_000;
    localparam int LF_HZ         = 32768;
    localparam int LF_DIV        = CLK_HZ / LF_HZ;
    localparam int SEC_TICKS_DEF = LF_HZ;
    localparam int SLOT_US       = 62500;
    localparam int SLOT_TICKS    = LF_HZ * SLOT_US / 1_000_000;
    localparam int FS_SHORT_S    = 5;
    localparam int FS_LONG_S     = 21;
    localparam int FS_W          = 5;

    // ------------------------------------------------------------
    // Banks and indexes
    // ------------------------------------------------------------
    localparam logic [1:0] BANK0 = 2'h0;
    localparam logic [1:0] BANK1 = 2'h1;
    localparam logic [1:0] BANK2 = 2'h2;

    localparam logic [6:0] IDX_CTRL1    = 7'h40;
    localparam logic [6:0] IDX_CTRL2    = 7'h41;
    localparam logic [6:0] IDX_STATUS   = 7'h42;
    localparam logic [6:0] IDX_LOCK     = 7'h47;
    localparam logic [6:0] IDX_CENTURY  = 7'h48;
    localparam logic [6:0] IDX_UP_PTR   = 7'h50;
    localparam logic [6:0] IDX_UP_DATA  = 7'h53;
    localparam logic [6:0] IDX_SHARED_LO = 7'h0e;
    localparam logic [6:0] IDX_SHARED_HI = 7'h3f;
    localparam logic [6:0] IDX_LOCKED_LO = 7'h38;
    localparam logic [6:0] IDX_BANK0_LO  = 7'h40;
    localparam logic [6:0] IDX_TOP       = 7'h7f;
    localparam logic [6:0] UP_GUARD_HI   = 7'h1f;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int C1_DLY_OPT   = 1;
    localparam int C1_LEVEL     = 2;
    localparam int C1_NOTE_CLR  = 3;
    localparam int C1_PF_MASK   = 4;
    localparam int C1_SOFT_OFF  = 5;
    localparam int C1_FS_RESET  = 6;
    localparam int C1_PF_FLAG   = 7;
    localparam int C2_ALARM_EN  = 0;
    localparam int C2_SRC_SEL   = 1;
    localparam int C2_TRAIN     = 2;
    localparam int C2_CALL_EN   = 3;
    localparam int C2_U1_EN     = 4;
    localparam int C2_U2_EN     = 5;
    localparam int C2_DLY_EN    = 6;
    localparam int ST_LEVEL     = 7;
    localparam int LK_UPPER     = 3;
    localparam int LK_RD_GUARD  = 4;
    localparam int LK_WR_GUARD  = 5;
    localparam int LK_MASK_WR   = 6;
    localparam int LK_LOCK      = 7;

    // ------------------------------------------------------------
    // Values and masks
    // ------------------------------------------------------------
    localparam logic [7:0] CTRL1_KEEP = 8'h16;
    localparam logic [7:0] CTRL2_KEEP = 8'h7f;
    localparam logic [7:0] LOCK_KEEP  = 8'hf8;
    localparam logic [5:0] STAT_INIT  = 6'h01;
    localparam logic [7:0] REG_ZERO   = 8'h00;
    localparam logic [7:0] READ_BLOCK = 8'hff;
    localparam logic [3:0] TRAIN_PAT  = 4'h7;

    // ------------------------------------------------------------
    // Synchroniser lanes
    // ------------------------------------------------------------
    localparam int SYNC_W   = 9;
    localparam int SI_RING_A = 0;
    localparam int SI_RING_B = 1;
    localparam int SI_U1     = 2;
    localparam int SI_U2     = 3;
    localparam int SI_SW     = 4;
    localparam int SI_VDD    = 5;
    localparam int SI_STBY   = 6;
    localparam int SI_FIRST  = 7;
    localparam int SI_MHR    = 8;
    localparam logic [SYNC_W-1:0] SYNC_IDLE = 9'h05f;

    typedef enum logic [1:0] {
        SUP_MAIN = 2'b00,
        SUP_BATT = 2'b01,
        SUP_HOLD = 2'b11
    } bbpw_sup_t;

endpackage

// file: bbpw_ctrl.sv
module bbpw_ctrl
    import bbpw_pkg::*;
#(
    parameter int TICKS_PER_SEC = SEC_TICKS_DEF
) (
    input  wire logic       clk,
    input  wire logic       sys_rst,
    input  wire logic       power_first_up,
    input  wire logic       master_hw_reset,
    input  wire logic       standby_present,
    input  wire logic       host_vdd_present,
    input  wire logic       switch_n,
    input  wire logic       call_alert_a_n,
    input  wire logic       call_alert_b_n,
    input  wire logic       uart1_wake_input_n,
    input  wire logic       uart2_wake_input_n,
    input  wire logic       alarm_match,
    input  wire logic [1:0] reg_bank,
    input  wire logic [6:0] reg_index,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    input  wire logic [7:0] reg_wdata,
    output logic      [7:0] reg_rdata,
    output logic            reg_rvalid,
    output logic            supply_enable_out_n,
    output logic            off_notice_n
);

    localparam int DIV_W  = $clog2(LF_DIV);
    localparam int SEC_W  = $clog2(TICKS_PER_SEC);
    localparam int SLOT_W = $clog2(SLOT_TICKS);

    if (TICKS_PER_SEC < 2) begin : g_chk
        $error("TICKS_PER_SEC must be at least 2");
    end

    function automatic logic in_range(input logic [6:0] v, input logic [6:0] lo, input logic [6:0] hi);
        in_range = (v >= lo) && (v <= hi);
    endfunction

    // ------------------------------------------------------------
    // Input synchronisers and slow tick
    // ------------------------------------------------------------
    logic [SYNC_W-1:0] sync1_q;
    logic [SYNC_W-1:0] sync2_q;
    logic [SYNC_W-1:0] samp_q;
    logic [DIV_W-1:0]  div_q;
    wire  [SYNC_W-1:0] raw_in = {master_hw_reset, power_first_up, standby_present, host_vdd_present,
                                 switch_n, uart2_wake_input_n, uart1_wake_input_n,
                                 call_alert_b_n, call_alert_a_n};
    wire               lf_tick = (div_q == DIV_W'(LF_DIV - 1));

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sync1_q <= SYNC_IDLE;
            sync2_q <= SYNC_IDLE;
        end else begin
            sync1_q <= raw_in;
            sync2_q <= sync1_q;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            div_q  <= '0;
            samp_q <= SYNC_IDLE;
        end else begin
            div_q <= lf_tick ? '0 : div_q + 1'b1;
            if (lf_tick) begin
                samp_q <= sync2_q;
            end
        end
    end

    // Edges are judged only on the slow tick, so closer repeats merge
    wire [SYNC_W-1:0] fall = {SYNC_W{lf_tick}} & samp_q & ~sync2_q;
    wire [SYNC_W-1:0] rise = {SYNC_W{lf_tick}} & ~samp_q & sync2_q;
    wire              first_up = sync2_q[SI_FIRST];
    wire              mhr      = sync2_q[SI_MHR];

    // ------------------------------------------------------------
    // Battery-backed registers
    // ------------------------------------------------------------
    logic [7:0] ctrl1_q;
    logic [7:0] ctrl2_q;
    logic [5:0] stat_q;
    logic [7:0] lock_q;
    logic [7:0] century_q;
    logic [6:0] ptr_q;
    logic       pf_flag_q;
    logic       on_q;
    logic       saved_q;
    logic       alarm_pend_q;
    logic       notice_q;
    logic       fs_run_q;
    logic [FS_W-1:0] fs_sec_q;
    bbpw_sup_t  sup_q;
    logic [SEC_W-1:0] hold_q;
    logic [7:0] lower_mem [0:127];
    logic [7:0] upper_mem [0:127];

    // ------------------------------------------------------------
    // Register decode
    // ------------------------------------------------------------
    wire in_bank1  = (reg_bank == BANK1);
    wire in_bank2  = (reg_bank == BANK2);
    wire hit_c1    = in_bank2 && (reg_index == IDX_CTRL1);
    wire hit_c2    = in_bank2 && (reg_index == IDX_CTRL2);
    wire hit_st    = in_bank2 && (reg_index == IDX_STATUS);
    wire hit_lk    = in_bank2 && (reg_index == IDX_LOCK);
    wire hit_cent  = in_bank1 && (reg_index == IDX_CENTURY);
    wire hit_ptr   = in_bank1 && (reg_index == IDX_UP_PTR);
    wire hit_win   = in_bank1 && (reg_index == IDX_UP_DATA);
    wire hit_shrd  = in_range(reg_index, IDX_SHARED_LO, IDX_SHARED_HI);
    wire hit_b0    = (reg_bank == BANK0) && in_range(reg_index, IDX_BANK0_LO, IDX_TOP);
    wire hit_low   = hit_shrd || hit_b0;
    wire in_locked = in_range(reg_index, IDX_LOCKED_LO, IDX_SHARED_HI);
    wire up_guard  = in_range(ptr_q, 7'h00, UP_GUARD_HI);

    wire wr_c1     = reg_wr && hit_c1;
    wire wr_c2     = reg_wr && hit_c2;
    wire rd_st     = reg_rd && hit_st;

    wire low_locked = lock_q[LK_LOCK] && in_locked;
    wire low_wr_ok  = hit_low && !low_locked && !(lock_q[LK_MASK_WR] && hit_b0);
    wire up_rd_blk  = lock_q[LK_UPPER] || (lock_q[LK_RD_GUARD] && up_guard);
    wire up_wr_ok   = !lock_q[LK_UPPER] && !(lock_q[LK_WR_GUARD] && up_guard)
                      && !lock_q[LK_MASK_WR];

    wire soft_off  = wr_c1 && reg_wdata[C1_SOFT_OFF];
    wire fs_clear  = wr_c1 && reg_wdata[C1_FS_RESET];
    wire note_clr  = wr_c1 && reg_wdata[C1_NOTE_CLR];
    wire pf_clr    = wr_c1 && reg_wdata[C1_PF_FLAG];

    // ------------------------------------------------------------
    // Event detection
    // ------------------------------------------------------------
    // Unless C1_PF_MASK is set, ring, UART and switch edges are ignored while on battery and for a second after
    wire in_mask   = (sup_q != SUP_MAIN) && !ctrl1_q[C1_PF_MASK];
    wire [SYNC_W-1:0] ev_fall = fall & {SYNC_W{!in_mask}};
    wire src_b     = ctrl2_q[C2_SRC_SEL];
    wire ring_fall = src_b ? ev_fall[SI_RING_B] : ev_fall[SI_RING_A];
    wire ring_lvl  = src_b ? sync2_q[SI_RING_B] : sync2_q[SI_RING_A];
    wire u1_fall   = ev_fall[SI_U1];
    wire u2_fall   = ev_fall[SI_U2];
    wire vdd_on    = sync2_q[SI_VDD];
    wire sw_on     = ev_fall[SI_SW] && !vdd_on;
    wire sw_off    = ev_fall[SI_SW] && vdd_on && !fs_run_q;
    wire vdd_lost  = fall[SI_VDD];

    // ------------------------------------------------------------
    // Ring pulse-train slots
    // ------------------------------------------------------------
    logic [SLOT_W-1:0] slot_q;
    logic              slot_edge_q;
    logic [2:0]        hist_q;
    wire               slot_end  = lf_tick && (slot_q == SLOT_W'(SLOT_TICKS - 1));
    wire               slot_cur  = slot_edge_q || ring_fall;
    wire               train_det = slot_end && ({hist_q, slot_cur} == TRAIN_PAT);
    wire               call_det  = ctrl2_q[C2_TRAIN] ? train_det : ring_fall;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            slot_q      <= '0;
            slot_edge_q <= 1'b0;
            hist_q      <= 3'h0;
        end else begin
            if (lf_tick) begin
                slot_q <= slot_end ? '0 : slot_q + 1'b1;
            end
            if (slot_end) begin
                hist_q      <= {hist_q[1:0], slot_cur};
                slot_edge_q <= 1'b0;
            end else if (ring_fall) begin
                slot_edge_q <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Seconds and fail-safe timer
    // ------------------------------------------------------------
    logic [SEC_W-1:0] sec_q;
    wire sec_tick  = lf_tick && (sec_q == SEC_W'(TICKS_PER_SEC - 1));
    wire [FS_W-1:0] fs_last = ctrl1_q[C1_DLY_OPT] ? FS_W'(FS_LONG_S - 1) : FS_W'(FS_SHORT_S - 1);
    wire fs_expire = fs_run_q && sec_tick && (fs_sec_q == fs_last);
    wire hold_end  = (sup_q == SUP_HOLD) && lf_tick && (hold_q == SEC_W'(TICKS_PER_SEC - 1));

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sec_q <= '0;
        end else if (lf_tick) begin
            sec_q <= sec_tick ? '0 : sec_q + 1'b1;
        end
    end

    // Fail-safe state is battery backed: a system reset mid-count must not rescue a hang
    always_ff @(posedge clk) begin
        if (first_up) begin
            fs_run_q <= 1'b0;
            fs_sec_q <= '0;
        end else if (fs_clear || vdd_lost || fs_expire) begin
            fs_run_q <= 1'b0;
            fs_sec_q <= '0;
        end else if (sw_off && ctrl2_q[C2_DLY_EN]) begin
            fs_run_q <= 1'b1;
            fs_sec_q <= '0;
        end else if (fs_run_q && sec_tick) begin
            fs_sec_q <= fs_sec_q + 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Power enable
    // ------------------------------------------------------------
    wire pf_block  = ctrl1_q[C1_PF_MASK] && pf_flag_q;
    wire wake_src  = (alarm_match && ctrl2_q[C2_ALARM_EN])
                   || (call_det && ctrl2_q[C2_CALL_EN])
                   || (u1_fall && ctrl2_q[C2_U1_EN])
                   || (u2_fall && ctrl2_q[C2_U2_EN]);
    wire wake_req  = sw_on || (wake_src && !pf_block && (sup_q == SUP_MAIN));
    wire off_req   = soft_off || (sw_off && !ctrl2_q[C2_DLY_EN]) || fs_expire;
    wire alarm_bat = alarm_match && ctrl2_q[C2_ALARM_EN] && (sup_q != SUP_MAIN);

    always_ff @(posedge clk) begin
        if (first_up) begin
            sup_q        <= SUP_MAIN;
            on_q         <= 1'b0;
            saved_q      <= 1'b0;
            alarm_pend_q <= 1'b0;
            hold_q       <= '0;
        end else begin
            if (alarm_bat) begin
                alarm_pend_q <= 1'b1;
            end
            case (sup_q)
                SUP_MAIN: begin
                    if (fall[SI_STBY]) begin
                        saved_q <= on_q;
                        on_q    <= 1'b0;
                        sup_q   <= SUP_BATT;
                    end else if (off_req) begin
                        on_q <= 1'b0; // Off wins over a wake in the same cycle
                    end else if (wake_req) begin
                        on_q <= 1'b1;
                    end
                end
                SUP_BATT: begin
                    on_q <= 1'b0;
                    if (rise[SI_STBY]) begin
                        hold_q <= '0;
                        sup_q  <= SUP_HOLD;
                    end
                end
                SUP_HOLD: begin
                    if (fall[SI_STBY]) begin
                        sup_q <= SUP_BATT;
                    end else if (hold_end) begin
                        sup_q        <= SUP_MAIN;
                        alarm_pend_q <= 1'b0;
                        if (!ctrl1_q[C1_PF_MASK]) begin
                            on_q <= saved_q || alarm_pend_q || alarm_bat;
                        end
                    end else if (lf_tick) begin
                        hold_q <= hold_q + 1'b1;
                    end
                end
                default: begin
                    sup_q <= SUP_MAIN;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Control and status registers
    // ------------------------------------------------------------
    wire [5:0] stat_set = {sw_off, fs_expire, u2_fall, u1_fall, call_det, alarm_match};
    wire [5:0] stat_clr = rd_st ? 6'h3f : 6'h00;

    always_ff @(posedge clk) begin
        if (first_up) begin
            ctrl1_q   <= REG_ZERO;
            ctrl2_q   <= REG_ZERO;
            pf_flag_q <= 1'b0;
            stat_q    <= STAT_INIT;
            century_q <= REG_ZERO;
            ptr_q     <= 7'h00;
        end else begin
            if (wr_c1) begin
                ctrl1_q <= reg_wdata & CTRL1_KEEP;
            end
            if (wr_c2) begin
                ctrl2_q <= reg_wdata & CTRL2_KEEP;
            end
            if (reg_wr && hit_cent) begin
                century_q <= reg_wdata;
            end
            if (reg_wr && hit_ptr) begin
                ptr_q <= reg_wdata[6:0];
            end
            // A new event beats the clearing read or write
            pf_flag_q <= (fall[SI_STBY] && (sup_q == SUP_MAIN)) || (pf_flag_q && !pf_clr);
            stat_q    <= (stat_q & ~stat_clr) | stat_set;
        end
    end

    always_ff @(posedge clk) begin
        if (first_up || mhr) begin
            lock_q <= REG_ZERO;
        end else if (reg_wr && hit_lk) begin
            lock_q <= lock_q | (reg_wdata & LOCK_KEEP);
        end
    end

    // Shutdown notice: edge mode lasts one slow-clock period
    always_ff @(posedge clk) begin
        if (first_up) begin
            notice_q <= 1'b0;
        end else if (sw_off) begin
            notice_q <= 1'b1;
        end else if (ctrl1_q[C1_LEVEL] ? note_clr : lf_tick) begin
            notice_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Battery-backed RAM
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (reg_wr && low_wr_ok) begin
            lower_mem[reg_index] <= reg_wdata;
        end
        if (reg_wr && hit_win && up_wr_ok) begin
            upper_mem[ptr_q] <= reg_wdata;
        end
    end

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    wire [7:0] rd_c1  = ctrl1_q | {pf_flag_q, 7'h00};
    wire [7:0] rd_st_v = {ring_lvl, 1'b0, stat_q};
    wire [7:0] rd_win = up_rd_blk ? READ_BLOCK : upper_mem[ptr_q];
    wire [7:0] rd_low = low_locked ? READ_BLOCK : lower_mem[reg_index];
    wire [7:0] rd_mux = hit_c1   ? rd_c1 :
                        hit_c2   ? ctrl2_q :
                        hit_st   ? rd_st_v :
                        hit_lk   ? lock_q :
                        hit_cent ? century_q :
                        hit_ptr  ? {1'b0, ptr_q} :
                        hit_win  ? rd_win :
                        hit_low  ? rd_low : REG_ZERO;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            reg_rdata  <= REG_ZERO;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_rd;
            if (reg_rd) begin
                reg_rdata <= rd_mux;
            end
        end
    end

    assign supply_enable_out_n = !on_q;
    assign off_notice_n        = !notice_q;

endmodule

// file: bbpw_ctrl_props.sv
module bbpw_ctrl_props
    import bbpw_pkg::*;
#(
    parameter int TICKS_PER_SEC = SEC_TICKS_DEF
) (
    input wire logic       clk,
    input wire logic       sys_rst,
    input wire logic       power_first_up,
    input wire logic       master_hw_reset,
    input wire logic [1:0] reg_bank,
    input wire logic [6:0] reg_index,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic       reg_rvalid,
    input wire logic       supply_enable_out_n
);
    timeunit 1ns;
    timeprecision 1ps;
    // --------
    // Shadows
    // --------
    logic [7:0] lk_q;
    logic [7:0] c1_q;
    logic       c1v_q;
    logic [1:0] rb_q;
    logic [6:0] ri_q;
    wire logic wr_c1 = reg_wr && reg_bank == BANK2 && reg_index == IDX_CTRL1;
    wire logic wr_lk = reg_wr && reg_bank == BANK2 && reg_index == IDX_LOCK;
    wire logic rd_c1 = rb_q == BANK2 && ri_q == IDX_CTRL1;
    wire logic rd_up = rb_q == BANK1 && ri_q == IDX_UP_DATA;
    wire logic rd_38 = ri_q >= IDX_LOCKED_LO && ri_q <= IDX_SHARED_HI;
    // Pin clears at once; the design lags by its synchroniser, so only safe
    always_ff @(posedge clk) begin
        if (reg_rd) begin
            rb_q <= reg_bank;
            ri_q <= reg_index;
        end
        if (power_first_up || master_hw_reset) begin
            lk_q <= REG_ZERO;
        end else if (wr_lk) begin
            lk_q <= lk_q | (reg_wdata & LOCK_KEEP);
        end
        if (power_first_up) begin
            c1v_q <= 1'b0;
        end else if (wr_c1) begin
            c1_q  <= reg_wdata;
            c1v_q <= 1'b1;
        end
    end
    // --------
    // Checks
    // --------
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    chk_read_answer: assert property (reg_rd |=> reg_rvalid)
        else $error("read strobe without answer");
    chk_rdata_hold: assert property (!reg_rvalid |-> $stable(reg_rdata))
        else $error("read data moved without answer");
    chk_first_up_off: assert property (power_first_up [*4] |=> supply_enable_out_n)
        else $error("supply enable on after first power-up");
    chk_soft_off: assert property (wr_c1 && reg_wdata[C1_SOFT_OFF] |-> ##[1:2] supply_enable_out_n)
        else $error("software off did not drop enable");
    chk_ctrl1_wonly: assert property (reg_rvalid && rd_c1 |-> (reg_rdata & 8'h69) == REG_ZERO)
        else $error("command bits read back nonzero");
    chk_ctrl1_keep: assert property (reg_rvalid && rd_c1 && c1v_q |-> ((reg_rdata ^ c1_q) & CTRL1_KEEP) == REG_ZERO)
        else $error("control one field lost");
    chk_upper_block: assert property (reg_rvalid && rd_up && lk_q[LK_UPPER] |-> reg_rdata == READ_BLOCK)
        else $error("blocked upper port read not ff");
    chk_lock_window: assert property (reg_rvalid && rd_38 && lk_q[LK_LOCK] |-> reg_rdata == READ_BLOCK)
        else $error("locked window read not ff");
    cover property (wr_c1 && reg_wdata[C1_SOFT_OFF]);
    cover property (reg_rvalid && rd_up && lk_q[LK_UPPER]);
    cover property (reg_rvalid && rd_38 && lk_q[LK_LOCK]);
endmodule

bind bbpw_ctrl bbpw_ctrl_props #(.TICKS_PER_SEC(TICKS_PER_SEC)) u_bbpw_ctrl_props (
    .clk, .sys_rst, .power_first_up, .master_hw_reset, .reg_bank, .reg_index, .reg_wr,
    .reg_rd, .reg_wdata, .reg_rdata, .reg_rvalid, .supply_enable_out_n);

// file: bbpw_partner.sv
module bbpw_partner (
    input  wire logic       clk,
    input  wire logic [4:0] kick,
    input  wire logic       supply_enable_out_n,
    output logic      [4:0] pins_n,
    output logic            host_vdd_present
);
    timeunit 1ns;
    timeprecision 1ps;
    // --------
    // Supply and event sources
    // --------
    logic [11:0] cnt_q [5] = '{default: 12'h000};
    logic [3:0]  vdd_q = 4'h0;
    // Long low pulses keep same-type events far apart
    always_ff @(posedge clk) begin
        vdd_q <= {vdd_q[2:0], !supply_enable_out_n};
        for (int i = 0; i < 5; i++) begin
            if (kick[i]) cnt_q[i] <= 12'hfa0;
            else if (cnt_q[i] != 12'h000) cnt_q[i] <= cnt_q[i] - 12'h001;
        end
    end
    always_comb for (int i = 0; i < 5; i++) pins_n[i] = (cnt_q[i] == 12'h000);
    assign host_vdd_present = vdd_q[3];
endmodule

// file: bbpw_ctrl_test.sv
module bbpw_ctrl_test
    import bbpw_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic       clk = 1'b0;
    logic       sys_rst = 1'b1;
    logic       power_first_up = 1'b0;
    logic       master_hw_reset = 1'b0;
    logic       standby_present = 1'b1;
    logic       alarm_match = 1'b0;
    logic       reg_wr = 1'b0;
    logic       reg_rd = 1'b0;
    logic [1:0] reg_bank = 2'h0;
    logic [6:0] reg_index = 7'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic [4:0] kick = 5'h00;
    logic [4:0] pins_n;
    logic [7:0] reg_rdata;
    logic       reg_rvalid, supply_enable_out_n, off_notice_n, host_vdd_present;
    int         mismatches = 0;
    int         compares = 0;
    always #10 clk = ~clk;
    bbpw_ctrl #(.TICKS_PER_SEC(2)) u_bbpw_ctrl (
        .clk, .sys_rst, .power_first_up, .master_hw_reset, .standby_present,
        .host_vdd_present, .switch_n(pins_n[4]), .call_alert_a_n(pins_n[0]),
        .call_alert_b_n(pins_n[1]), .uart1_wake_input_n(pins_n[2]), .uart2_wake_input_n(pins_n[3]),
        .alarm_match, .reg_bank, .reg_index, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
        .reg_rvalid, .supply_enable_out_n, .off_notice_n);
    bbpw_partner u_bbpw_partner (.clk, .kick, .supply_enable_out_n, .pins_n, .host_vdd_present);
    // --------
    // Tasks
    // --------
    task automatic final_report();
        if (mismatches == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [1:0] b, input logic [6:0] i, input logic [7:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_bank <= b;
        reg_index <= i;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [1:0] b, input logic [6:0] i, input logic [7:0] e);
        int n;
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_bank <= b;
        reg_index <= i;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        for (n = 0; n < 8 && reg_rvalid !== 1'b1; n++) @(posedge clk) #1;
        chk({7'h00, reg_rvalid}, 8'h01);
        chk(reg_rdata, e);
        if (n == 8) final_report();
    endtask
    // Slow tick plus synchroniser can take over 1525 cycles
    task automatic wait_en(input logic v);
        int n;
        for (n = 0; n < 16000 && supply_enable_out_n !== v; n++) @(posedge clk) #1;
        chk({7'h00, supply_enable_out_n}, {7'h00, v});
        if (n == 16000) final_report();
    endtask
    task automatic kick_pin(input logic [4:0] v);
        @(posedge clk);
        kick <= v;
        @(posedge clk);
        kick <= 5'h00;
    endtask
    // --------
    // Sequence
    // --------
    initial begin
        repeat (10) @(posedge clk);
        sys_rst <= 1'b0;
        power_first_up <= 1'b1;
        repeat (5) @(posedge clk);
        power_first_up <= 1'b0;
        repeat (5) @(posedge clk);
        chk({7'h00, supply_enable_out_n}, 8'h01);
        rd(BANK2, IDX_STATUS, 8'h81);
        rd(BANK2, IDX_STATUS, 8'h80);
        wr(BANK2, IDX_CTRL1, 8'h7e);
        rd(BANK2, IDX_CTRL1, 8'h16);
        wr(BANK2, IDX_CTRL1, REG_ZERO);
        wr(BANK2, IDX_CTRL2, 8'hff);
        rd(BANK2, IDX_CTRL2, 8'h7f);
        wr(BANK2, IDX_CTRL2, 8'h10);
        kick_pin(5'h04);
        wait_en(1'b0);
        rd(BANK2, IDX_STATUS, 8'h84);
        kick_pin(5'h10);
        wait_en(1'b1);
        rd(BANK2, IDX_STATUS, 8'ha0);
        chk({7'h00, off_notice_n}, 8'h00);
        wr(BANK2, IDX_CTRL2, 8'h01);
        @(posedge clk) alarm_match <= 1'b1;
        @(posedge clk) alarm_match <= 1'b0;
        wait_en(1'b0);
        rd(BANK2, IDX_STATUS, 8'h81);
        wr(BANK2, IDX_CTRL1, 8'h20);
        wait_en(1'b1);
        @(posedge clk) alarm_match <= 1'b1;
        @(posedge clk) alarm_match <= 1'b0;
        wait_en(1'b0);
        @(posedge clk) standby_present <= 1'b0;
        wait_en(1'b1);
        @(posedge clk) standby_present <= 1'b1;
        wait_en(1'b0);
        rd(BANK2, IDX_CTRL1, 8'h80);
        wr(BANK2, IDX_CTRL1, 8'h80);
        rd(BANK2, IDX_CTRL1, REG_ZERO);
        wr(BANK2, IDX_CTRL2, 8'h41);
        kick_pin(5'h10);
        repeat (6000) @(posedge clk);
        chk({7'h00, supply_enable_out_n}, 8'h00);
        rd(BANK2, IDX_STATUS, 8'ha1);
        kick_pin(5'h10);
        wait_en(1'b1);
        rd(BANK2, IDX_STATUS, 8'h90);
        @(posedge clk) sys_rst <= 1'b1;
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
        rd(BANK2, IDX_CTRL2, 8'h41);
        wr(BANK1, IDX_UP_PTR, 8'h05);
        wr(BANK1, IDX_UP_DATA, 8'ha5);
        rd(BANK1, IDX_UP_DATA, 8'ha5);
        wr(BANK2, IDX_LOCK, 8'h08);
        rd(BANK1, IDX_UP_DATA, READ_BLOCK);
        wr(BANK2, IDX_LOCK, REG_ZERO);
        rd(BANK2, IDX_LOCK, 8'h08);
        wr(BANK0, 7'h3a, 8'h5c);
        rd(BANK1, 7'h3a, 8'h5c);
        wr(BANK0, 7'h45, 8'h33);
        wr(BANK2, IDX_LOCK, 8'h80);
        rd(BANK2, 7'h3a, READ_BLOCK);
        wr(BANK2, IDX_LOCK, 8'h40);
        wr(BANK0, 7'h45, 8'hcc);
        rd(BANK0, 7'h45, 8'h33);
        @(posedge clk) master_hw_reset <= 1'b1;
        repeat (5) @(posedge clk);
        master_hw_reset <= 1'b0;
        repeat (5) @(posedge clk);
        rd(BANK2, IDX_LOCK, REG_ZERO);
        final_report();
    end
endmodule
